//--- rtl/bsfc_pkg.sv
// Shared constants and types of the boot-sector flash host controller.
// Assumes a 100 MHz system clock and an asynchronous 5 V flash device on the far side.
package bsfc_pkg;
	// Clock rate
	localparam int CLK_MHZ = 100;
	// Flash bus timing, in ns
	localparam int SETUP_NS = 20;
	localparam int STROBE_NS = 60;
	localparam int HOLD_NS = 30;
	localparam int RST_PULSE_NS = 500;
	localparam int RST_REC_NS = 1000;
	// Same timing in clock cycles, rounded up
	localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] RST_PULSE_CYC = 8'((RST_PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] RST_REC_CYC = 8'((RST_REC_NS * CLK_MHZ + 999) / 1000);
	// Register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_CFG = 8'h0c;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_RDATA = 8'h14;
	// Operation codes written to the command register
	localparam logic [3:0] OP_READ = 4'h1;
	localparam logic [3:0] OP_PROG = 4'h2;
	localparam logic [3:0] OP_SECT = 4'h3;
	localparam logic [3:0] OP_CHIP = 4'h4;
	localparam logic [3:0] OP_SUSP = 4'h5;
	localparam logic [3:0] OP_RESUME = 4'h6;
	localparam logic [3:0] OP_BYP_ON = 4'h7;
	localparam logic [3:0] OP_BYP_OFF = 4'h8;
	localparam logic [3:0] OP_RESET = 4'h9;
	// Status register bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_TMO = 2;
	localparam int ST_SUSP = 3;
	localparam int ST_BYP = 4;
	localparam int ST_RB = 5;
	localparam int ST_TOG6 = 6;
	localparam int ST_TOG2 = 7;
	// Data line positions of the toggle bits
	localparam int DQ_TOG6 = 6;
	localparam int DQ_TOG2 = 2;
	// Data line enables: byte mode drives the A-1 line, plus the low byte on writes; word mode writes drive all
	localparam logic [15:0] OE_BYTE_WR = 16'h80ff;
	localparam logic [15:0] OE_BYTE_ADR = 16'h8000;
	localparam logic [15:0] OE_WORD_WR = 16'hffff;
	// Pins toward the flash
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic reset_n;
		logic byte_n;
		logic [18:0] addr;
		logic [15:0] dq;
		logic [15:0] dq_oe;
	} bsfc_pins_s;
	// One request to the bus cycle engine
	typedef struct packed {
		logic start;
		logic write;
		logic rst;
		logic [19:0] addr;
		logic [15:0] data;
	} bsfc_req_s;
	// One step of a command sequence
	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] data;
		logic last;
	} bsfc_cyc_s;
	// Engine states
	typedef enum logic [5:0] {
		E_IDLE = 6'b000001,
		E_SETUP = 6'b000010,
		E_STROBE = 6'b000100,
		E_HOLD = 6'b001000,
		E_RST = 6'b010000,
		E_REC = 6'b100000
	} bsfc_eng_e;
	// Sequencer states
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_WRITE = 5'b00010,
		S_POLL = 5'b00100,
		S_READ = 5'b01000,
		S_RESET = 5'b10000
	} bsfc_seq_e;
	// Pin levels after reset: all strobes high, bus released
	localparam bsfc_pins_s PINS_RST = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_n: 1'b1,
		byte_n: 1'b1, addr: 19'h00000, dq: 16'h0000, dq_oe: 16'h0000};
endpackage

//--- rtl/bsfc_cycle.sv
// Single flash bus cycle engine: one write, one read or one reset pulse.
// Assumes requests arrive only while idle; pins are registered.
`timescale 1ns/1ps
module bsfc_cycle
	import bsfc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire bsfc_req_s req_i,
	input wire logic byte_i,
	input wire logic [15:0] dq_i,
	output bsfc_pins_s pins_o,
	output logic done_o,
	output logic [15:0] rdata_o
);
	// Whole engine state
	typedef struct packed {
		bsfc_eng_e st;
		logic [7:0] cnt;
		logic write;
		logic bm;
		logic done;
		logic [15:0] rdata;
		bsfc_pins_s pins;
	} bsfc_eng_s;

	bsfc_eng_s r; // Current state
	bsfc_eng_s next_r; // Next state

	// Cycle sequencing
	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		unique case (r.st)
			E_IDLE:
			begin
				// Byte pin only changes between cycles
				next_r.pins.byte_n = ~byte_i;
				next_r.bm = byte_i;
				next_r.pins.dq_oe = byte_i ? OE_BYTE_ADR : 16'h0000;
				if (req_i.rst)
				begin
					next_r.pins.reset_n = 1'b0;
					next_r.cnt = RST_PULSE_CYC - 8'h01;
					next_r.st = E_RST;
				end
				else if (req_i.start)
				begin
					// Byte mode puts A-1 on dq15 and floats dq8-14
					next_r.write = req_i.write;
					next_r.pins.ce_n = 1'b0;
					next_r.pins.addr = byte_i ? req_i.addr[19:1] : req_i.addr[18:0];
					next_r.pins.dq = byte_i ? {req_i.addr[0], 7'h00, req_i.data[7:0]}
						: req_i.data;
					if (req_i.write)
						next_r.pins.dq_oe = byte_i ? OE_BYTE_WR : OE_WORD_WR;
					next_r.cnt = SETUP_CYC - 8'h01;
					next_r.st = E_SETUP;
				end
			end
			E_SETUP:
			begin
				// Only one strobe at a time, always under chip select
				if (r.cnt == 8'h00)
				begin
					next_r.pins.we_n = ~r.write;
					next_r.pins.oe_n = r.write;
					next_r.cnt = STROBE_CYC - 8'h01;
					next_r.st = E_STROBE;
				end
				else
					next_r.cnt = r.cnt - 8'h01;
			end
			E_STROBE:
			begin
				if (r.cnt == 8'h00)
				begin
					// Read data taken just before output strobe rises
					if (!r.write)
						next_r.rdata = r.bm ? {8'h00, dq_i[7:0]} : dq_i;
					next_r.pins.we_n = 1'b1;
					next_r.pins.oe_n = 1'b1;
					next_r.cnt = HOLD_CYC - 8'h01;
					next_r.st = E_HOLD;
				end
				else
					next_r.cnt = r.cnt - 8'h01;
			end
			E_HOLD:
			begin
				if (r.cnt == 8'h00)
				begin
					next_r.pins.ce_n = 1'b1;
					next_r.pins.dq_oe = r.bm ? OE_BYTE_ADR : 16'h0000;
					next_r.done = 1'b1;
					next_r.st = E_IDLE;
				end
				else
					next_r.cnt = r.cnt - 8'h01;
			end
			E_RST:
			begin
				// Reset pin low aborts the device operation
				if (r.cnt == 8'h00)
				begin
					next_r.pins.reset_n = 1'b1;
					next_r.cnt = RST_REC_CYC - 8'h01;
					next_r.st = E_REC;
				end
				else
					next_r.cnt = r.cnt - 8'h01;
			end
			E_REC:
			begin
				if (r.cnt == 8'h00)
				begin
					next_r.done = 1'b1;
					next_r.st = E_IDLE;
				end
				else
					next_r.cnt = r.cnt - 8'h01;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			r <= '{st: E_IDLE, cnt: 8'h00, write: 1'b0, bm: 1'b0, done: 1'b0,
				rdata: 16'h0000, pins: PINS_RST};
		else
			r <= next_r;
	end

	assign pins_o = r.pins;
	assign done_o = r.done;
	assign rdata_o = r.rdata;
endmodule // bsfc_cycle

//--- rtl/bsfc_ctrl.sv
// Host controller for a boot-sector flash: Wishbone registers, command sequencer, polling.
// Assumes a classic Wishbone master and a flash wired to flash_o, dq_i and ready_busy_i.
//
// Notes on behaviour
// - Program by full sequence; device self-times
// - Bypass program needs two writes, not four
// - Completion seen on pin and status bits
// - Host drives separate chip, write, output strobes
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
module bsfc_ctrl
	import bsfc_pkg::*;
#(
	parameter logic [31:0] POLL_LIMIT = 32'd200000, // Status reads before timeout
	parameter logic [19:0] UNLK1_W = 20'h00555, // First unlock address, word mode
	parameter logic [19:0] UNLK2_W = 20'h002aa, // Second unlock address, word mode
	parameter logic [19:0] UNLK1_B = 20'h00aaa, // First unlock address, byte mode
	parameter logic [19:0] UNLK2_B = 20'h00555, // Second unlock address, byte mode
	parameter logic [7:0] CMD_UNLK1 = 8'haa, // First unlock data
	parameter logic [7:0] CMD_UNLK2 = 8'h55, // Second unlock data
	parameter logic [7:0] CMD_PROG = 8'ha0, // Program setup
	parameter logic [7:0] CMD_ERASE = 8'h80, // Erase setup
	parameter logic [7:0] CMD_SECT = 8'h30, // Sector erase and resume
	parameter logic [7:0] CMD_CHIP = 8'h10, // Chip erase
	parameter logic [7:0] CMD_SUSP = 8'hb0, // Erase suspend
	parameter logic [7:0] CMD_BYP = 8'h20, // Unlock bypass entry
	parameter logic [7:0] CMD_BYPX1 = 8'h90, // Unlock bypass exit, first
	parameter logic [7:0] CMD_BYPX2 = 8'h00 // Unlock bypass exit, second
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output bsfc_pins_s flash_o,
	input wire logic [15:0] dq_i,
	input wire logic ready_busy_i
);
	// Whole sequencer state
	typedef struct packed {
		bsfc_seq_e st;
		logic [3:0] op; // Operation requested by software
		logic [3:0] cur; // Sequence being issued now
		logic [2:0] step; // Write index inside a sequence
		logic pend; // Engine request still to issue
		logic [19:0] addr;
		logic [15:0] wdata;
		logic byte_mode;
		logic bypass;
		logic suspended;
		logic susp_req;
		logic done;
		logic tmo;
		logic have_prev;
		logic [15:0] prev;
		logic tog6;
		logic tog2;
		logic [15:0] rdata;
		logic [31:0] polls;
		logic ack;
		logic [31:0] dat;
		bsfc_req_s req;
	} bsfc_ctl_s;

	bsfc_ctl_s r; // Current state
	bsfc_ctl_s next_r; // Next state
	logic eng_done; // Engine finished a cycle
	logic [15:0] eng_rdata; // Data of last read cycle
	bsfc_cyc_s cyc; // Current sequence step
	logic [31:0] stat; // Status word
	logic [31:0] wmask; // Byte lane mask of a write

	// Command sequence table: address and data of each write
	function automatic bsfc_cyc_s seq_step(input logic [3:0] op, input logic [2:0] step,
		input logic byp, input logic bm, input logic [19:0] a, input logic [15:0] d);
		logic [19:0] u1;
		logic [19:0] u2;
		bsfc_cyc_s c;
		u1 = bm ? UNLK1_B : UNLK1_W;
		u2 = bm ? UNLK2_B : UNLK2_W;
		c = '{addr: u1, data: {8'h00, CMD_UNLK1}, last: 1'b0};
		unique case (op)
			OP_PROG:
			begin
				// Two writes in bypass, four otherwise
				if (byp)
				begin
					if (step == 3'd0)
						c = '{addr: a, data: {8'h00, CMD_PROG}, last: 1'b0};
					else
						c = '{addr: a, data: d, last: 1'b1};
				end
				else if (step == 3'd1)
					c = '{addr: u2, data: {8'h00, CMD_UNLK2}, last: 1'b0};
				else if (step == 3'd2)
					c = '{addr: u1, data: {8'h00, CMD_PROG}, last: 1'b0};
				else if (step == 3'd3)
					c = '{addr: a, data: d, last: 1'b1};
			end
			OP_SECT, OP_CHIP:
			begin
				// Six writes; the last names a sector or the chip
				if (step == 3'd1 || step == 3'd4)
					c = '{addr: u2, data: {8'h00, CMD_UNLK2}, last: 1'b0};
				else if (step == 3'd2)
					c = '{addr: u1, data: {8'h00, CMD_ERASE}, last: 1'b0};
				else if (step == 3'd5)
					c = (op == OP_SECT) ? '{addr: a, data: {8'h00, CMD_SECT}, last: 1'b1}
						: '{addr: u1, data: {8'h00, CMD_CHIP}, last: 1'b1};
			end
			OP_SUSP:
				c = '{addr: a, data: {8'h00, CMD_SUSP}, last: 1'b1};
			OP_RESUME:
				c = '{addr: a, data: {8'h00, CMD_SECT}, last: 1'b1};
			OP_BYP_ON:
			begin
				if (step == 3'd1)
					c = '{addr: u2, data: {8'h00, CMD_UNLK2}, last: 1'b0};
				else if (step == 3'd2)
					c = '{addr: u1, data: {8'h00, CMD_BYP}, last: 1'b1};
			end
			OP_BYP_OFF:
				c = (step == 3'd0) ? '{addr: a, data: {8'h00, CMD_BYPX1}, last: 1'b0}
					: '{addr: a, data: {8'h00, CMD_BYPX2}, last: 1'b1};
			default:
				c = '{addr: a, data: d, last: 1'b1};
		endcase
		return c;
	endfunction

	// Bus cycle engine toward the flash pins
	bsfc_cycle u_cycle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.req_i(r.req),
		.byte_i(r.byte_mode),
		.dq_i(dq_i),
		.pins_o(flash_o),
		.done_o(eng_done),
		.rdata_o(eng_rdata)
	);

	// Lookups for the current step, status word and write mask
	always_comb
	begin
		cyc = seq_step(r.cur, r.step, r.bypass, r.byte_mode, r.addr, r.wdata);
		stat = 32'h00000000;
		stat[ST_BUSY] = (r.st != S_IDLE);
		stat[ST_DONE] = r.done;
		stat[ST_TMO] = r.tmo;
		stat[ST_SUSP] = r.suspended;
		stat[ST_BYP] = r.bypass;
		stat[ST_RB] = ready_busy_i;
		stat[ST_TOG6] = r.tog6;
		stat[ST_TOG2] = r.tog2;
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	end

	// Sequencer and register slave
	always_comb
	begin
		next_r = r;
		next_r.req.start = 1'b0;
		next_r.req.rst = 1'b0;
		next_r.ack = 1'b0;
		unique case (r.st)
			S_IDLE:
			begin
			end
			S_WRITE:
			begin
				if (r.pend)
				begin
					// Each write latches command, address and data
					next_r.req = '{start: 1'b1, write: 1'b1, rst: 1'b0,
						addr: cyc.addr, data: cyc.data};
					next_r.pend = 1'b0;
				end
				else if (eng_done)
				begin
					if (!cyc.last)
					begin
						next_r.step = r.step + 3'd1;
						next_r.pend = 1'b1;
					end
					else
					begin
						next_r.pend = 1'b1;
						next_r.have_prev = 1'b0;
						next_r.st = S_POLL;
						if (r.cur == OP_BYP_ON || r.cur == OP_BYP_OFF)
						begin
							next_r.bypass = (r.cur == OP_BYP_ON);
							// No poll follows, so nothing stays pending
							next_r.pend = 1'b0;
							next_r.done = 1'b1;
							next_r.st = S_IDLE;
						end
						// Hold or release an erase
						if (r.cur == OP_SUSP)
							next_r.suspended = 1'b1;
						if (r.cur == OP_RESUME)
							next_r.suspended = 1'b0;
					end
				end
			end
			S_POLL:
			begin
				if (r.pend)
				begin
					next_r.req = '{start: 1'b1, write: 1'b0, rst: 1'b0,
						addr: r.addr, data: 16'h0000};
					next_r.pend = 1'b0;
				end
				else if (eng_done)
				begin
					// Toggle bits compared over two reads
					next_r.polls = r.polls + 32'd1;
					next_r.prev = eng_rdata;
					next_r.have_prev = 1'b1;
					next_r.pend = 1'b1;
					if (r.have_prev && (eng_rdata[DQ_TOG6] != r.prev[DQ_TOG6]))
						next_r.tog6 = 1'b1;
					if (r.have_prev && (eng_rdata[DQ_TOG2] != r.prev[DQ_TOG2]))
						next_r.tog2 = 1'b1;
					// Done once DQ6 stops toggling and the pin shows ready
					if (r.have_prev && (eng_rdata[DQ_TOG6] == r.prev[DQ_TOG6]) && ready_busy_i)
					begin
						next_r.pend = 1'b0;
						next_r.done = 1'b1;
						next_r.st = S_IDLE;
					end
					else if (r.polls == POLL_LIMIT - 32'd1)
					begin
						next_r.pend = 1'b0;
						next_r.tmo = 1'b1;
						next_r.done = 1'b1;
						next_r.st = S_IDLE;
					end
					else if (r.susp_req && (r.cur == OP_SECT || r.cur == OP_CHIP
						|| r.cur == OP_RESUME))
					begin
						// Break into a running erase with a suspend
						next_r.susp_req = 1'b0;
						next_r.cur = OP_SUSP;
						next_r.step = 3'd0;
						next_r.st = S_WRITE;
					end
				end
			end
			S_READ:
			begin
				if (r.pend)
				begin
					next_r.req = '{start: 1'b1, write: 1'b0, rst: 1'b0,
						addr: r.addr, data: 16'h0000};
					next_r.pend = 1'b0;
				end
				else if (eng_done)
				begin
					next_r.rdata = eng_rdata;
					next_r.done = 1'b1;
					next_r.st = S_IDLE;
				end
			end
			S_RESET:
			begin
				if (r.pend)
				begin
					next_r.req.rst = 1'b1;
					next_r.pend = 1'b0;
				end
				else if (eng_done)
				begin
					// Device is back in array read after the pulse
					next_r.bypass = 1'b0;
					next_r.suspended = 1'b0;
					next_r.done = 1'b1;
					next_r.st = S_IDLE;
				end
			end
		endcase
		// Register slave, after the sequencer so a set wins
		if (wb_cyc_i && wb_stb_i && !r.ack)
		begin
			next_r.ack = 1'b1;
			next_r.dat = 32'h00000000;
			if (wb_we_i)
			begin
				if (wb_adr_i == REG_ADDR)
					next_r.addr = (r.addr & ~wmask[19:0]) | (wb_dat_i[19:0] & wmask[19:0]);
				else if (wb_adr_i == REG_WDATA)
					next_r.wdata = (r.wdata & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				else if (wb_adr_i == REG_CFG && wb_sel_i[0] && r.st == S_IDLE)
					next_r.byte_mode = wb_dat_i[0];
				else if (wb_adr_i == REG_CMD && wb_sel_i[0])
				begin
					// Suspend only breaks into an erase poll
					if (r.st == S_POLL && wb_dat_i[3:0] == OP_SUSP
						&& (r.cur == OP_SECT || r.cur == OP_CHIP || r.cur == OP_RESUME))
						next_r.susp_req = 1'b1;
					else if (r.st == S_IDLE && wb_dat_i[3:0] >= OP_READ
						&& wb_dat_i[3:0] <= OP_RESET)
					begin
						next_r.op = wb_dat_i[3:0];
						next_r.cur = wb_dat_i[3:0];
						next_r.step = 3'd0;
						next_r.pend = 1'b1;
						next_r.done = 1'b0;
						next_r.tmo = 1'b0;
						next_r.tog6 = 1'b0;
						next_r.tog2 = 1'b0;
						next_r.polls = 32'd0;
						// A late suspend must not carry into a new operation
						next_r.susp_req = 1'b0;
						next_r.have_prev = 1'b0;
						if (wb_dat_i[3:0] == OP_READ)
							next_r.st = S_READ;
						else if (wb_dat_i[3:0] == OP_RESET)
							next_r.st = S_RESET;
						else
							next_r.st = S_WRITE;
					end
				end
			end
			else
			begin
				unique case (wb_adr_i)
					REG_CMD: next_r.dat = {28'h0000000, r.op};
					REG_ADDR: next_r.dat = {12'h000, r.addr};
					REG_WDATA: next_r.dat = {16'h0000, r.wdata};
					REG_CFG: next_r.dat = {31'h00000000, r.byte_mode};
					REG_STAT: next_r.dat = stat;
					REG_RDATA: next_r.dat = {16'h0000, r.rdata};
					default: next_r.dat = 32'h00000000;
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			r <= '{st: S_IDLE, op: 4'h0, cur: 4'h0, step: 3'd0, pend: 1'b0,
				addr: 20'h00000, wdata: 16'h0000, byte_mode: 1'b0, bypass: 1'b0,
				suspended: 1'b0, susp_req: 1'b0, done: 1'b0, tmo: 1'b0, have_prev: 1'b0,
				prev: 16'h0000, tog6: 1'b0, tog2: 1'b0, rdata: 16'h0000, polls: 32'd0,
				ack: 1'b0, dat: 32'h00000000,
				req: '{start: 1'b0, write: 1'b0, rst: 1'b0, addr: 20'h00000, data: 16'h0000}};
		else
			r <= next_r;
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;

	// Write cycles issued within one operation, for checking
	logic [3:0] wr_cnt;
	always_ff @(posedge clk_i)
	begin
		if (rst_i || (r.st == S_IDLE))
			wr_cnt <= 4'h0;
		else if (r.req.start && r.req.write)
			wr_cnt <= wr_cnt + 4'h1;
	end

	strobe_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(!flash_o.we_n && !flash_o.oe_n)) else $error("write and output strobe both low");
	strobe_chip_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!flash_o.we_n || !flash_o.oe_n) |-> !flash_o.ce_n) else $error("strobe without chip select");
	bypass_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.st == S_WRITE && next_r.st == S_POLL && r.cur == OP_PROG && r.bypass)
		|-> wr_cnt == 4'h2) else $error("bypass program not two writes");
	prog_four_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.st == S_WRITE && next_r.st == S_POLL && r.cur == OP_PROG && !r.bypass)
		|-> wr_cnt == 4'h4) else $error("program sequence not four writes");
	done_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.st == S_POLL && next_r.st == S_IDLE && !next_r.tmo)
		|-> ready_busy_i && eng_rdata[DQ_TOG6] == r.prev[DQ_TOG6])
		else $error("completion without stable toggle bit");
	reset_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(flash_o.reset_n) |-> !flash_o.reset_n [*8]) else $error("reset pulse too short");
	ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
endmodule // bsfc_ctrl

//--- bench/bsfc_flash_model.sv
// Behavioural boot-sector flash, array folded to four words a sector.
// Assumes controller pins in; the bench merges dq_o with driven lines.
`timescale 1ns/1ps
module bsfc_flash_model
	import bsfc_pkg::*;
#(
	parameter int BUSY_CYC = 150, // Program length; erase twice this
	parameter logic [4:0] PROT_SEC = 5'h05 // Protected sector
)
(
	input wire logic clk_i,
	input wire bsfc_pins_s pins_i,
	output logic [15:0] dq_o,
	output logic ready_busy_o
);
	logic [15:0] mem [0:127]; // Folded array
	logic [15:0] rd = '0, w; // Read data
	logic [7:0] h1 = '0, h2 = '0, h3 = '0, k; // Command history
	logic pp = 0, byp = 0, susp = 0, chip = 0, tg6 = 0, tg2 = 0, ul; // Modes
	logic [4:0] es = '0; // Sector under erase
	int pb = 0, eb = 0; // Cycles left
	// Top boot: last 32K words split as 16K, 4K, 4K, 8K
	function automatic logic [4:0] sec(input logic [18:0] a);
		if (a[18:15] != 4'hf)
			return {1'b0, a[18:15]};
		else if (!a[14])
			return 5'd15;
		else if (a[13])
			return 5'd18;
		else
			return a[12] ? 5'd17 : 5'd16;
	endfunction
	// Erased when shipped
	initial foreach (mem[i]) mem[i] = 16'hffff;
	// Busy pin; released lines show the inverse
	assign ready_busy_o = !(pb > 0 || (eb > 0 && !susp));
	assign dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? rd : ~rd;
	// Write latches command, address, data
	always @(posedge pins_i.we_n)
	if (!pins_i.ce_n && pins_i.reset_n)
	begin
		k = pins_i.dq[7:0];
		ul = h2 == 8'haa && h1 == 8'h55;
		// Unlock data off its address breaks a sequence
		if ((k == 8'haa && pins_i.addr[10:0] != 11'h555) ||
			(k == 8'h55 && pins_i.addr[10:0] != 11'h2aa))
			k = 8'h00;
		if (pp)
		begin
			// Self-timed, protected sectors kept
			if (sec(pins_i.addr) != PROT_SEC)
				mem[{sec(pins_i.addr), pins_i.addr[1:0]}] &= pins_i.dq;
			pb = BUSY_CYC;
			pp = 1'b0;
		end
		else if (k == 8'ha0 && (byp || ul))
			pp = 1'b1;
		else if (k == 8'h20 && ul)
			byp = 1'b1;
		else if (k == 8'h90)
			byp = 1'b0;
		else if (k == 8'hb0 && eb > 0)
			susp = 1'b1;
		else if (k == 8'h30 && susp)
			susp = 1'b0;
		else if ((k == 8'h30 || k == 8'h10) && ul && h3 == 8'h80)
		begin
			// All-protected target starts nothing
			chip = k == 8'h10;
			es = sec(pins_i.addr);
			if (chip || es != PROT_SEC)
				eb = 2 * BUSY_CYC;
		end
		h3 = h2;
		h2 = h1;
		h1 = k;
	end
	// Algorithms run; reset pin aborts all
	always @(posedge clk_i)
	if (!pins_i.reset_n)
	begin
		{pp, byp, susp, h1} = '0;
		pb = 0;
		eb = 0;
	end
	else
	begin
		if (pb > 0)
			pb--;
		if (eb > 0 && !susp)
			eb--;
		// Target only goes to ones
		if (eb == 1 && !susp)
			for (int i = 0; i < 128; i++)
				if ((i >> 2) != PROT_SEC && (chip || (i >> 2) == es))
					mem[i] = 16'hffff;
	end
	// Array or status at read strobe
	always @(negedge pins_i.oe_n)
	if (!pins_i.ce_n)
	begin
		w = mem[{sec(pins_i.addr), pins_i.addr[1:0]}];
		if (!ready_busy_o)
		begin
			tg6 = !tg6;
			w[6] = tg6;
			w[7] = pb > 0 ? ~w[7] : 1'b0;
		end
		if (eb > 0 && (chip || sec(pins_i.addr) == es))
		begin
			tg2 = !tg2;
			w[2] = tg2;
		end
		if (!pins_i.byte_n)
			w = {~rd[15:8], pins_i.dq[15] ? w[15:8] : w[7:0]};
		rd = w;
	end
endmodule // bsfc_flash_model

//--- bench/bsfc_ctrl_bench.sv
// Self-checking bench of the boot-sector flash host controller.
// Assumes the flash model on the pins; bench is Wishbone master.
`timescale 1ns/1ps
`define CK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
	$display("BAD t=%0t got %h exp %h", $time, a, b); end end
module bsfc_ctrl_bench
	import bsfc_pkg::*;
;
	logic clk_i = 1'b0, rst_i = 1'b1; // Clock, reset
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, rb, a15; // Bus, pins
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = '0, dat_o, rdat; // Bus data
	logic [15:0] mdq, dq_w, oe_cap; // Data lines
	logic [18:0] adr_cap;
	bsfc_pins_s fl;
	int err_total = 0, samples_checked = 0, cyc_cnt = 0, wr_n = 0, rst_len = 0;
	always #5 clk_i = ~clk_i;
	// Wire: controller where enabled, else the model
	assign dq_w = (fl.dq_oe & fl.dq) | (~fl.dq_oe & mdq);
	bsfc_ctrl #(.POLL_LIMIT(32'd500)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.flash_o(fl), .dq_i(dq_w), .ready_busy_i(rb));
	bsfc_flash_model model_u (.clk_i(clk_i), .pins_i(fl), .dq_o(mdq),
		.ready_busy_o(rb));
	// Count writes; strobes stay apart
	always @(negedge fl.we_n)
	begin
		wr_n++;
		`CK({fl.ce_n, fl.oe_n}, 2'b01)
	end
	// Pins at read strobe
	always @(negedge fl.oe_n)
	begin
		oe_cap = fl.dq_oe;
		adr_cap = fl.addr;
		a15 = fl.dq[15];
	end
	// Reset pulse length and hang limit
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (!fl.reset_n)
			rst_len++;
		if (cyc_cnt == 50000)
		begin
			err_total++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One classic access, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	// Poll status until idle
	task automatic wt();
		do
			wb(1'b0, REG_STAT, 32'h0);
		while (rdat[ST_BUSY] !== 1'b0);
	endtask
	// Start an operation, optionally wait
	task automatic op(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d,
		input logic w);
		wb(1'b1, REG_ADDR, {12'h0, a});
		wb(1'b1, REG_WDATA, {16'h0, d});
		wb(1'b1, REG_CMD, {28'h0, c});
		if (w)
			wt();
	endtask
	// Read back one location
	task automatic rdb(input logic [19:0] a, input logic [15:0] e);
		op(OP_READ, a, 16'h0, 1'b1);
		wb(1'b0, REG_RDATA, 32'h0);
		`CK(rdat[15:0], e)
	endtask
	// Start sector erase, then hold it
	task automatic hold(input logic [19:0] a);
		op(OP_SECT, a, 16'h0, 1'b0);
		repeat (120)
			@(posedge clk_i);
		wb(1'b1, REG_CMD, {28'h0, OP_SUSP});
		wt();
	endtask
	task automatic t_prog();
		wb(1'b0, 8'h40, 32'h0);
		`CK(rdat, 32'h0)
		wr_n = 0;
		op(OP_PROG, 20'h00011, 16'h1234, 1'b1);
		`CK(wr_n, 4)
		`CK(rdat[ST_DONE], 1'b1)
		`CK(rdat[ST_TOG6], 1'b1)
		`CK(rdat[ST_RB], 1'b1)
		rdb(20'h00011, 16'h1234);
		op(OP_PROG, 20'h00011, 16'hff00, 1'b1);
		rdb(20'h00011, 16'h1200);
		$display("prog done");
	endtask
	task automatic t_byp();
		op(OP_BYP_ON, 20'h0, 16'h0, 1'b1);
		`CK(rdat[ST_BYP], 1'b1)
		wr_n = 0;
		op(OP_PROG, 20'h10012, 16'h0f0f, 1'b1);
		`CK(wr_n, 2)
		rdb(20'h10012, 16'h0f0f);
		op(OP_BYP_OFF, 20'h0, 16'h0, 1'b1);
		`CK(rdat[ST_BYP], 1'b0)
		$display("bypass done");
	endtask
	task automatic t_erase();
		op(OP_PROG, 20'h08001, 16'h5555, 1'b1);
		op(OP_SECT, 20'h08001, 16'h0, 1'b1);
		`CK(rdat[ST_TOG2], 1'b1)
		rdb(20'h08001, 16'hffff);
		rdb(20'h10012, 16'h0f0f);
		// Neighbouring small boot sectors erase apart
		op(OP_PROG, 20'h7c000, 16'h4444, 1'b1);
		op(OP_PROG, 20'h7d000, 16'h2222, 1'b1);
		op(OP_SECT, 20'h7d000, 16'h0, 1'b1);
		rdb(20'h7c000, 16'h4444);
		rdb(20'h7d000, 16'hffff);
		op(OP_PROG, 20'h28000, 16'h0000, 1'b1);
		rdb(20'h28000, 16'hffff);
		op(OP_SECT, 20'h28000, 16'h0, 1'b1);
		`CK(rdat[ST_TMO], 1'b0)
		$display("erase done");
	endtask
	task automatic t_susp();
		op(OP_PROG, 20'h18003, 16'h0aa0, 1'b1);
		hold(20'h18003);
		`CK(rdat[ST_SUSP], 1'b1)
		op(OP_PROG, 20'h20000, 16'h3c3c, 1'b1);
		rdb(20'h20000, 16'h3c3c);
		op(OP_RESUME, 20'h18003, 16'h0, 1'b1);
		`CK(rdat[ST_SUSP], 1'b0)
		rdb(20'h18003, 16'hffff);
		$display("suspend done");
	endtask
	task automatic t_rst();
		op(OP_PROG, 20'h30000, 16'h1111, 1'b1);
		hold(20'h30000);
		rst_len = 0;
		op(OP_RESET, 20'h0, 16'h0, 1'b1);
		`CK(rst_len, int'(RST_PULSE_CYC))
		`CK(rdat[ST_SUSP], 1'b0)
		rdb(20'h30000, 16'h1111);
		$display("reset done");
	endtask
	task automatic t_byte();
		wb(1'b1, REG_CFG, 32'h1);
		wb(1'b0, REG_CFG, 32'h0);
		`CK(rdat, 32'h1)
		op(OP_READ, 20'h00023, 16'h0, 1'b1);
		`CK(fl.byte_n, 1'b0)
		`CK(oe_cap, OE_BYTE_ADR)
		`CK({adr_cap, a15}, 20'h00023)
		wb(1'b0, REG_RDATA, 32'h0);
		`CK(rdat[7:0], 8'h12)
		wb(1'b1, REG_CFG, 32'h0);
		op(OP_CHIP, 20'h0, 16'h0, 1'b1);
		rdb(20'h20000, 16'hffff);
		$display("byte and chip done");
	endtask
	// Main sequence
	initial
	begin
		repeat (20)
			@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_prog();
		t_byp();
		t_erase();
		t_susp();
		t_rst();
		t_byte();
		wrap_up();
	end
endmodule // bsfc_ctrl_bench
